// >>> logic/sbme_pkg.sv
// shared types and constants of the system control and block move executor
package sbme_pkg;

  typedef enum logic [3:0] {
    SBME_NOP, SBME_SLEEP, SBME_LDC_IMM, SBME_LDC_REG, SBME_LDC_MEM,
    SBME_STC_REG, SBME_STC_MEM, SBME_AND_COND_REG_IMM, SBME_ORC, SBME_XOR_COND_REG_IMM,
    SBME_TRAP, SBME_RTE, SBME_MOVE_B, SBME_MOVE_W
  } sbme_op_type;

  // am_step is post-increment for loads and pre-decrement for stores
  typedef enum logic [2:0] {
    AM_IND, AM_DISP16, AM_DISP24, AM_STEP, AM_ABS16, AM_ABS24
  } sbme_mode_type;

  typedef enum logic [2:0] {
    RF_ADDR, RF_SP, RF_PC, RF_RD8, RF_SRC, RF_DST, RF_CNT8, RF_CNT16
  } sbme_reg_type;

  typedef struct packed {
    sbme_op_type op;
    sbme_mode_type mode;
    logic adv;
    logic [7:0] imm;
    logic [1:0] vec;
    logic [31:0] disp;
    logic [31:0] base;
    logic [31:0] sp;
    logic [23:0] pc;
    logic [7:0] rs8;
    logic [15:0] cnt;
    logic [31:0] src;
    logic [31:0] dst;
  } sbme_insn_type;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } sbme_mem_type;

  typedef struct packed {
    logic we;
    sbme_reg_type sel;
    logic [31:0] data;
  } sbme_wb_type;

  localparam int ST_SHORT = 2;
  localparam int ST_TRAP_NORM = 14;
  localparam int ST_TRAP_ADV = 16;
  localparam int ST_RTE = 10;
  localparam int ST_IND = 6;
  localparam int ST_DISP16 = 8;
  localparam int ST_DISP24 = 12;
  localparam int ST_STEP = 8;
  localparam int ST_ABS16 = 8;
  localparam int ST_ABS24 = 10;
  localparam int ST_MOVE_BASE = 8;
  localparam int ST_MOVE_BYTE = 4;
  localparam int ST_MOVE_SETUP = 4;
  localparam int ST_MOVE_TAIL = 4;
  localparam int STEP_W = 20;
  localparam int ADDR_STEP = 2;
  localparam int CCR_IBIT = 7;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [23:0] TRAP_VEC_BASE = 24'h000010;
  localparam int FIFO_DEPTH = 16;

endpackage : sbme_pkg

// >>> logic/sbme_fifo.sv
// byte fifo between the read and write halves of a block move
`timescale 1ns/10ps
`default_nettype none
module sbme_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, empty, do_push, do_pop;

  always_comb begin
    full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    empty = (wr_q == rd_q);
    do_push = in_valid && !full;
    do_pop = out_ready && !empty;
    wr_d = do_push ? wr_q + 1'b1 : wr_q;
    rd_d = do_pop ? rd_q + 1'b1 : rd_q;
    in_ready = !full;
    out_valid = !empty;
    out_data = store_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset, only the pointers say what is valid
  always_ff @(posedge mclk) begin
    if (do_push) begin
      store_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : sbme_fifo
`default_nettype wire

// >>> logic/sbme_exec.sv
// executor for trap, return, sleep, condition register ops and block moves
// How it works
// - trap pushes pc, condition, loads vector, masks
// - return pops condition then pc, restoring flags
// - sleep powers down, flags untouched, two states
// - word load post-increment adds two to address
// - word store pre-decrement subtracts two first
// - every store form leaves condition bits unchanged
// - byte-count move copies bytes, skips on zero
// - word-count move uses full sixteen-bit count
// - move time is eight plus four per byte
// - counts assume on-chip memory, waits add states
`timescale 1ns/10ps
`default_nettype none
module sbme_exec
  import sbme_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire sbme_insn_type issue_insn,
  output logic done,
  input wire logic wake,
  output logic power_down,
  output logic [7:0] cond_reg,
  output sbme_mem_type mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output sbme_wb_type reg_wb
);
  typedef enum {S_IDLE, S_RUN} sbme_state_type;

  sbme_state_type state_q, state_d;
  sbme_insn_type insn_q, insn_d;
  logic [STEP_W-1:0] cyc_q, cyc_d, total_q, total_d, rel;
  logic [7:0] ccr_q, ccr_d;
  logic [23:0] tmp_q, tmp_d;
  logic sleep_q, sleep_d, need, stall, push, fifo_rdy, fifo_vld;
  logic [7:0] fifo_out;
  logic [15:0] n, k;

  function automatic logic [STEP_W-1:0] mode_states(sbme_mode_type m);
    case (m)
      AM_IND: mode_states = STEP_W'(ST_IND);
      AM_DISP16: mode_states = STEP_W'(ST_DISP16);
      AM_DISP24: mode_states = STEP_W'(ST_DISP24);
      AM_STEP: mode_states = STEP_W'(ST_STEP);
      AM_ABS16: mode_states = STEP_W'(ST_ABS16);
      default: mode_states = STEP_W'(ST_ABS24);
    endcase
  endfunction : mode_states

  function automatic logic [STEP_W-1:0] state_count(sbme_insn_type i);
    case (i.op)
      SBME_TRAP: state_count = STEP_W'(i.adv ? ST_TRAP_ADV : ST_TRAP_NORM);
      SBME_RTE: state_count = STEP_W'(ST_RTE);
      SBME_LDC_MEM, SBME_STC_MEM: state_count = mode_states(i.mode);
      SBME_MOVE_B:
        state_count = STEP_W'(ST_MOVE_BASE + ST_MOVE_BYTE * int'(i.cnt[7:0]));
      SBME_MOVE_W:
        state_count = STEP_W'(ST_MOVE_BASE + ST_MOVE_BYTE * int'(i.cnt));
      default: state_count = STEP_W'(ST_SHORT);
    endcase
  endfunction : state_count

  function automatic logic [23:0] calc_ea(sbme_insn_type i);
    case (i.mode)
      AM_DISP16: calc_ea = 24'(i.base + {{16{i.disp[15]}}, i.disp[15:0]});
      AM_DISP24: calc_ea = 24'(i.base + {{8{i.disp[23]}}, i.disp[23:0]});
      AM_ABS16: calc_ea = {{8{i.disp[15]}}, i.disp[15:0]};
      AM_ABS24: calc_ea = i.disp[23:0];
      AM_STEP: calc_ea = (i.op == SBME_STC_MEM) ?
                         24'(i.base - ADDR_STEP) : i.base[23:0];
      default: calc_ea = i.base[23:0];
    endcase
  endfunction : calc_ea

  sbme_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(mem_rdata[7:0]),
    .out_valid(fifo_vld),
    .out_ready(mem_cmd.req && mem_cmd.we && mem_ack && !mem_cmd.word),
    .out_data(fifo_out)
  );

  always_comb begin
    state_d = state_q;
    insn_d = insn_q;
    cyc_d = cyc_q;
    total_d = total_q;
    ccr_d = ccr_q;
    tmp_d = tmp_q;
    sleep_d = sleep_q && !wake;
    done = 1'b0;
    need = 1'b0;
    push = 1'b0;
    stall = 1'b0;
    mem_cmd = '0;
    reg_wb = '0;
    n = (insn_q.op == SBME_MOVE_B) ? {8'h00, insn_q.cnt[7:0]} : insn_q.cnt;
    rel = cyc_q - STEP_W'(ST_MOVE_SETUP);
    k = rel[17:2];
    issue_ready = (state_q == S_IDLE) && !sleep_q;
    case (state_q)
      S_IDLE: begin
        if (issue_valid && !sleep_q) begin
          state_d = S_RUN;
          insn_d = issue_insn;
          cyc_d = '0;
          total_d = state_count(issue_insn);
        end
      end
      S_RUN: begin
        case (insn_q.op)
          SBME_NOP: if (cyc_q == 1) begin
            reg_wb = '{1'b1, RF_PC, 32'(insn_q.pc + 24'(ADDR_STEP))};
          end
          SBME_SLEEP: if (cyc_q == 1) sleep_d = 1'b1;
          SBME_LDC_IMM: if (cyc_q == 1) ccr_d = insn_q.imm;
          SBME_LDC_REG: if (cyc_q == 1) ccr_d = insn_q.rs8;
          SBME_AND_COND_REG_IMM: if (cyc_q == 1) ccr_d = ccr_q & insn_q.imm;
          SBME_ORC: if (cyc_q == 1) ccr_d = ccr_q | insn_q.imm;
          SBME_XOR_COND_REG_IMM: if (cyc_q == 1) ccr_d = ccr_q ^ insn_q.imm;
          SBME_STC_REG: if (cyc_q == 1) begin
            reg_wb = '{1'b1, RF_RD8, {24'h000000, ccr_q}};
          end
          SBME_LDC_MEM: begin
            if (cyc_q == 0) begin
              need = 1'b1;
              mem_cmd = '{1'b1, 1'b0, 1'b1, calc_ea(insn_q), 16'h0000};
              if (mem_ack) ccr_d = mem_rdata[15:8];
            end else if (cyc_q == 1 && insn_q.mode == AM_STEP) begin
              reg_wb = '{1'b1, RF_ADDR, insn_q.base + ADDR_STEP};
            end
          end
          SBME_STC_MEM: begin
            if (insn_q.mode == AM_STEP && cyc_q == 0) begin
              reg_wb = '{1'b1, RF_ADDR, insn_q.base - ADDR_STEP};
            end else if (cyc_q == ((insn_q.mode == AM_STEP) ? 1 : 0)) begin
              need = 1'b1;
              mem_cmd = '{1'b1, 1'b1, 1'b1, calc_ea(insn_q), {ccr_q, 8'h00}};
            end
          end
          SBME_TRAP: begin
            case (cyc_q)
              0: begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b1, 1'b1, 24'(insn_q.sp - ADDR_STEP),
                            insn_q.pc[15:0]};
              end
              1: begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b1, 1'b1, 24'(insn_q.sp - 2 * ADDR_STEP),
                            {ccr_q, insn_q.adv ? insn_q.pc[23:16] : 8'h00}};
              end
              2: begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b0, 1'b1, TRAP_VEC_BASE +
                            (insn_q.adv ? {20'h00000, insn_q.vec, 2'b00}
                                        : {21'h000000, insn_q.vec, 1'b0}),
                            16'h0000};
                if (mem_ack) begin
                  tmp_d = insn_q.adv ? {mem_rdata[7:0], 16'h0000}
                                     : {8'h00, mem_rdata};
                end
              end
              3: if (insn_q.adv) begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b0, 1'b1, TRAP_VEC_BASE +
                            {20'h00000, insn_q.vec, 2'b10}, 16'h0000};
                if (mem_ack) tmp_d[15:0] = mem_rdata;
              end
              4: reg_wb = '{1'b1, RF_SP, insn_q.sp - 2 * ADDR_STEP};
              5: ccr_d[CCR_IBIT] = 1'b1;
              default: if (cyc_q == total_q - 1) begin
                reg_wb = '{1'b1, RF_PC, {8'h00, tmp_q}};
              end
            endcase
          end
          SBME_RTE: begin
            case (cyc_q)
              0: begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b0, 1'b1, insn_q.sp[23:0], 16'h0000};
                if (mem_ack) begin
                  ccr_d = mem_rdata[15:8];
                  tmp_d[23:16] = insn_q.adv ? mem_rdata[7:0] : 8'h00;
                end
              end
              1: begin
                need = 1'b1;
                mem_cmd = '{1'b1, 1'b0, 1'b1, 24'(insn_q.sp + ADDR_STEP),
                            16'h0000};
                if (mem_ack) tmp_d[15:0] = mem_rdata;
              end
              2: reg_wb = '{1'b1, RF_SP, insn_q.sp + 2 * ADDR_STEP};
              default: if (cyc_q == total_q - 1) begin
                reg_wb = '{1'b1, RF_PC, {8'h00, tmp_q}};
              end
            endcase
          end
          SBME_MOVE_B, SBME_MOVE_W: if (n != 16'h0000) begin
            // the fifo lets a stalled write hold the byte already read
            if (cyc_q >= STEP_W'(ST_MOVE_SETUP) &&
                cyc_q < total_q - STEP_W'(ST_MOVE_TAIL)) begin
              if (cyc_q[1:0] == 2'b00) begin
                need = 1'b1;
                mem_cmd = '{fifo_rdy, 1'b0, 1'b0,
                            24'(insn_q.src + 32'(k)), 16'h0000};
                push = fifo_rdy && mem_ack;
              end else if (cyc_q[1:0] == 2'b01) begin
                need = 1'b1;
                mem_cmd = '{fifo_vld, 1'b1, 1'b0,
                            24'(insn_q.dst + 32'(k)), {8'h00, fifo_out}};
              end
            end else if (cyc_q == total_q - 4) begin
              reg_wb = '{1'b1, RF_SRC, insn_q.src + 32'(n)};
            end else if (cyc_q == total_q - 3) begin
              reg_wb = '{1'b1, RF_DST, insn_q.dst + 32'(n)};
            end else if (cyc_q == total_q - 2) begin
              reg_wb = '{1'b1, (insn_q.op == SBME_MOVE_B) ? RF_CNT8 : RF_CNT16,
                         32'h00000000};
            end
          end
          default: ;
        endcase
        // a slow memory holds the step, so the count only holds on-chip
        stall = need && !(mem_cmd.req && mem_ack);
        if (!stall) begin
          if (cyc_q == total_q - 1) begin
            done = 1'b1;
            state_d = S_IDLE;
          end else begin
            cyc_d = cyc_q + 1'b1;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    power_down = sleep_q;
    cond_reg = ccr_q;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      insn_q <= '0;
      cyc_q <= '0;
      total_q <= '0;
      ccr_q <= CCR_RESET;
      tmp_q <= '0;
      sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      insn_q <= insn_d;
      cyc_q <= cyc_d;
      total_q <= total_d;
      ccr_q <= ccr_d;
      tmp_q <= tmp_d;
      sleep_q <= sleep_d;
    end
  end

  // helper counters for the timing checks
  logic [STEP_W-1:0] age_q, stalls_q;
  logic accept, run;
  assign accept = issue_valid && issue_ready;
  assign run = (state_q == S_RUN);
  always_ff @(posedge mclk) begin
    if (!reset_n || accept) begin
      age_q <= '0;
      stalls_q <= '0;
    end else if (run) begin
      age_q <= age_q + 1'b1;
      stalls_q <= stalls_q + STEP_W'(stall);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_trap_time;
    done && insn_q.op == SBME_TRAP |-> age_q - stalls_q + 1 ==
      (insn_q.adv ? 16 : 14);
  endproperty
  a_trap_time: assert property (p_trap_time)
    else $error("trap state count wrong");
  property p_trap_mask;
    done && insn_q.op == SBME_TRAP |=> cond_reg[7];
  endproperty
  a_trap_mask: assert property (p_trap_mask)
    else $error("trap left mask bit clear");
  property p_rte_flags;
    run && insn_q.op == SBME_RTE && cyc_q == 0 && mem_ack |=>
      cond_reg == $past(mem_rdata[15:8]);
  endproperty
  a_rte_flags: assert property (p_rte_flags)
    else $error("return did not restore flags");
  property p_sleep;
    done && insn_q.op == SBME_SLEEP |=> power_down && $stable(cond_reg);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep misbehaved");
  property p_ldc_imm;
    accept && issue_insn.op == SBME_LDC_IMM |-> ##3
      cond_reg == $past(issue_insn.imm, 3);
  endproperty
  a_ldc_imm: assert property (p_ldc_imm)
    else $error("immediate load wrong");
  property p_postinc;
    reg_wb.we && insn_q.op == SBME_LDC_MEM && insn_q.mode == AM_STEP |->
      reg_wb.data == insn_q.base + 2;
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("post-increment not by two");
  property p_predec;
    mem_cmd.req && mem_cmd.we && insn_q.op == SBME_STC_MEM &&
      insn_q.mode == AM_STEP |-> mem_cmd.addr == 24'(insn_q.base - 2) &&
      mem_cmd.wdata[15:8] == cond_reg;
  endproperty
  a_predec: assert property (p_predec)
    else $error("pre-decrement store wrong");
  property p_store_keeps;
    run && $past(run) && (insn_q.op == SBME_STC_MEM ||
      insn_q.op == SBME_STC_REG) |=> $stable(cond_reg);
  endproperty
  a_store_keeps: assert property (p_store_keeps)
    else $error("store changed flags");
  property p_move_zero;
    accept && (issue_insn.op == SBME_MOVE_B && issue_insn.cnt[7:0] == 0 ||
      issue_insn.op == SBME_MOVE_W && issue_insn.cnt == 0) |=>
      (!mem_cmd.req)[*8];
  endproperty
  a_move_zero: assert property (p_move_zero)
    else $error("zero-count move touched memory");
  property p_move_time;
    done && (insn_q.op == SBME_MOVE_B || insn_q.op == SBME_MOVE_W) |->
      age_q - stalls_q + 1 == STEP_W'(8 + 4 * int'(n));
  endproperty
  a_move_time: assert property (p_move_time)
    else $error("move state count wrong");
endmodule : sbme_exec
`default_nettype wire

// >>> testbench/sbme_mem_model.sv
// on-chip memory model facing the executor's memory port
`timescale 1ns/10ps
`default_nettype none
module sbme_mem_model
  import sbme_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire sbme_mem_type mem_cmd,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [256];
  logic tick_q;
  logic [15:0] last_q;
  logic [7:0] a;
  assign a = mem_cmd.addr[7:0];
  // on-chip memory answers at once; slow mode answers every other cycle
  assign mem_ack = mem_cmd.req && (!slow || tick_q);
  // idle bus shows the inverse of the last answer, never a stale match
  always_comb begin
    mem_rdata = ~last_q;
    if (mem_ack && mem_cmd.word)
      mem_rdata = {mem[a], mem[a + 8'h01]};
    else if (mem_ack)
      mem_rdata = {~last_q[15:8], mem[a]};
  end
  // plain always: the bench preloads the same array
  always @(posedge mclk) begin
    tick_q <= reset_n ? ~tick_q : 1'b0;
    if (!reset_n)
      last_q <= 16'h0000;
    else if (mem_ack)
      last_q <= mem_rdata;
    if (mem_ack && mem_cmd.we && mem_cmd.word) begin
      mem[a] <= mem_cmd.wdata[15:8];
      mem[a + 8'h01] <= mem_cmd.wdata[7:0];
    end else if (mem_ack && mem_cmd.we)
      mem[a] <= mem_cmd.wdata[7:0];
  end
endmodule : sbme_mem_model
`default_nettype wire

// >>> testbench/sbme_exec_tb_top.sv
// testbench of the system control and block move executor
`timescale 1ns/10ps
`default_nettype none
module sbme_exec_tb_top;
  import sbme_pkg::*;
  logic mclk, reset_n, issue_valid, issue_ready, done, wake;
  logic power_down, slow, mem_ack;
  logic [7:0] cond_reg;
  logic [15:0] mem_rdata;
  sbme_insn_type issue_insn;
  sbme_mem_type mem_cmd;
  sbme_wb_type reg_wb;
  logic [31:0] wb_q [8];
  int failures = 0;
  int samples_checked = 0;
  sbme_exec DUT (.mclk(mclk), .reset_n(reset_n),
    .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_insn(issue_insn), .done(done), .wake(wake),
    .power_down(power_down), .cond_reg(cond_reg), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .reg_wb(reg_wb));
  sbme_mem_model ram (.mclk(mclk), .reset_n(reset_n), .slow(slow),
    .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // keep the last value written to each register
  always @(posedge mclk) begin
    if (reg_wb.we === 1'b1)
      wb_q[reg_wb.sel] <= reg_wb.data;
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] ex,
                     input string m);
    samples_checked++;
    if (seen !== ex) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, ex);
    end
  endtask : chk
  function automatic sbme_insn_type mk(input sbme_op_type op,
                                       input sbme_mode_type md,
                                       input logic [7:0] v);
    mk = '0;
    mk.op = op;
    mk.mode = md;
    mk.imm = v;
    mk.rs8 = v;
  endfunction : mk
  // offer one instruction, count run cycles up to done
  task automatic run(input sbme_insn_type i, output int n);
    int k;
    issue_insn = i;
    issue_valid = 1'b1;
    for (k = 0; k < 50 && issue_ready !== 1'b1; k++) @(negedge mclk);
    @(posedge mclk);
    #1 issue_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 400 || k == 50) begin
        failures++;
        stop_test();
      end
    end
    @(posedge mclk);
    #1;
  endtask : run
  task automatic t_short();
    sbme_op_type ops [7] = '{SBME_LDC_IMM, SBME_AND_COND_REG_IMM, SBME_ORC,
      SBME_XOR_COND_REG_IMM, SBME_LDC_REG, SBME_STC_REG, SBME_NOP};
    logic [7:0] arg [7] = '{8'h5A, 8'h0F, 8'hC0, 8'hFF, 8'h81, 8'h00, 8'h00};
    logic [7:0] ex [7] = '{8'h5A, 8'h0A, 8'hCA, 8'h35, 8'h81, 8'h81, 8'h81};
    sbme_insn_type i;
    int n;
    for (int k = 0; k < 7; k++) begin
      i = mk(ops[k], AM_IND, arg[k]);
      i.pc = 24'h000100;
      run(i, n);
      chk(n, 2, "short states");
      chk(cond_reg, ex[k], "cond");
    end
    chk(wb_q[RF_RD8][7:0], 8'h81, "store to reg");
    chk(wb_q[RF_PC][23:0], 24'h000102, "nop pc");
    $display("short ops finished");
  endtask : t_short
  task automatic t_mem();
    sbme_insn_type i;
    int n;
    ram.mem[8'h70] = 8'h3C;
    i = mk(SBME_STC_MEM, AM_STEP, 8'h00);
    i.base = 32'h60;
    run(i, n);
    chk(n, ST_STEP, "predec states");
    chk(ram.mem[8'h5E], 8'h81, "predec data");
    chk(wb_q[RF_ADDR], 32'h5E, "predec addr");
    chk(cond_reg, 8'h81, "store keeps cond");
    i = mk(SBME_LDC_MEM, AM_STEP, 8'h00);
    i.base = 32'h70;
    run(i, n);
    chk(n, ST_STEP, "postinc states");
    chk(cond_reg, 8'h3C, "postinc load");
    chk(wb_q[RF_ADDR], 32'h72, "postinc addr");
    i = mk(SBME_STC_MEM, AM_DISP16, 8'h00);
    i.base = 32'h50;
    i.disp = 32'h10;
    run(i, n);
    chk(n, ST_DISP16, "disp states");
    chk({ram.mem[8'h60], cond_reg}, 16'h3C3C, "disp store");
    ram.mem[8'h68] = 8'hC3;
    ram.mem[8'h6C] = 8'h5A;
    i = mk(SBME_STC_MEM, AM_IND, 8'h00);
    i.base = 32'h64;
    run(i, n);
    chk(n, ST_IND, "ind states");
    chk(ram.mem[8'h64], 8'h3C, "ind store");
    i = mk(SBME_LDC_MEM, AM_ABS24, 8'h00);
    i.disp = 32'h68;
    run(i, n);
    chk(n, ST_ABS24, "abs24 states");
    chk(cond_reg, 8'hC3, "abs24 load");
    i = mk(SBME_STC_MEM, AM_ABS16, 8'h00);
    i.disp = 32'h6A;
    run(i, n);
    chk(n, ST_ABS16, "abs16 states");
    chk(ram.mem[8'h6A], 8'hC3, "abs16 store");
    i = mk(SBME_LDC_MEM, AM_DISP24, 8'h00);
    i.base = 32'h70;
    i.disp = 32'h00FFFFFC;
    run(i, n);
    chk(n, ST_DISP24, "disp24 states");
    chk(cond_reg, 8'h5A, "disp24 load");
    $display("memory forms finished");
  endtask : t_mem
  task automatic t_trap();
    sbme_insn_type i;
    int n;
    ram.mem[8'h12] = 8'h12;
    ram.mem[8'h13] = 8'h34;
    ram.mem[8'h19] = 8'h22;
    ram.mem[8'h1A] = 8'h33;
    ram.mem[8'h1B] = 8'h44;
    run(mk(SBME_LDC_IMM, AM_IND, 8'h05), n);
    i = mk(SBME_TRAP, AM_IND, 8'h00);
    i.vec = 2'd1;
    i.sp = 32'hC0;
    i.pc = 24'h000ABC;
    run(i, n);
    chk(n, 14, "trap states");
    chk(cond_reg, 8'h85, "mask set");
    chk({ram.mem[8'hBC], ram.mem[8'hBE], ram.mem[8'hBF]}, 24'h050ABC,
        "push");
    chk(wb_q[RF_SP], 32'hBC, "trap sp");
    chk(wb_q[RF_PC][23:0], 24'h001234, "vector");
    i.vec = 2'd2;
    i.adv = 1'b1;
    i.pc = 24'h56ABCD;
    run(i, n);
    chk(n, 16, "adv trap states");
    chk({ram.mem[8'hBC], ram.mem[8'hBD], ram.mem[8'hBE], ram.mem[8'hBF]},
        32'h8556ABCD, "adv push");
    chk(wb_q[RF_PC][23:0], 24'h223344, "adv vector");
    ram.mem[8'hBC] = 8'h2A;
    i = mk(SBME_RTE, AM_IND, 8'h00);
    i.sp = 32'hBC;
    i.adv = 1'b1;
    run(i, n);
    chk(n, ST_RTE, "rte states");
    chk(cond_reg, 8'h2A, "rte cond");
    chk(wb_q[RF_PC][23:0], 24'h56ABCD, "rte pc");
    chk(wb_q[RF_SP], 32'hC0, "rte sp");
    $display("trap and return finished");
  endtask : t_trap
  task automatic t_sleep();
    int n;
    run(mk(SBME_LDC_IMM, AM_IND, 8'h33), n);
    run(mk(SBME_SLEEP, AM_IND, 8'h00), n);
    chk(n, 2, "sleep states");
    chk({power_down, cond_reg}, 9'h133, "asleep");
    issue_insn = mk(SBME_NOP, AM_IND, 8'h00);
    issue_valid = 1'b1;
    repeat (5) begin
      @(negedge mclk);
      chk(issue_ready | done, 1'b0, "refused");
    end
    @(posedge mclk);
    #1 issue_valid = 1'b0;
    wake = 1'b1;
    @(posedge mclk);
    #1 wake = 1'b0;
    chk({power_down, cond_reg}, 9'h033, "woken");
    $display("sleep finished");
  endtask : t_sleep
  task automatic mv(input sbme_op_type op, input logic [15:0] cnt,
                    input int nb, input logic sl);
    sbme_insn_type i;
    int n;
    for (int k = 0; k < 24; k++) begin
      ram.mem[8'h40 + k] = 8'hA0 ^ k[7:0];
      ram.mem[8'h80 + k] = 8'h00;
    end
    slow = sl;
    wb_q[RF_SRC] = 32'hFFFFFFFF;
    i = mk(op, AM_IND, 8'h00);
    i.cnt = cnt;
    i.src = 32'h40;
    i.dst = 32'h80;
    run(i, n);
    slow = 1'b0;
    if (sl)
      chk(n > 8 + 4 * nb, 1'b1, "slow move");
    else
      chk(n, 8 + 4 * nb, "move states");
    for (int k = 0; k < 24; k++)
      chk(ram.mem[8'h80 + k], k < nb ? 8'hA0 ^ k[7:0] : 8'h00,
          "copy");
    if (nb > 0) begin
      chk(wb_q[RF_SRC], 32'h40 + nb, "src end");
      chk(wb_q[RF_DST], 32'h80 + nb, "dst end");
      chk(wb_q[op == SBME_MOVE_B ? RF_CNT8 : RF_CNT16][7:0], 8'h00,
          "count end");
    end else begin
      chk(wb_q[RF_SRC], 32'hFFFFFFFF, "no write back");
    end
    $display("block move of %0d bytes finished", nb);
  endtask : mv
  initial begin
    reset_n = 1'b0;
    issue_valid = 1'b0;
    issue_insn = '0;
    wake = 1'b0;
    slow = 1'b0;
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk({power_down, cond_reg}, {1'b0, CCR_RESET}, "reset");
    t_short();
    t_mem();
    t_trap();
    t_sleep();
    mv(SBME_MOVE_B, 16'hFF05, 5, 1'b0);
    mv(SBME_MOVE_B, 16'h0100, 0, 1'b0);
    mv(SBME_MOVE_W, 16'h0014, 20, 1'b0);
    mv(SBME_MOVE_W, 16'h0006, 6, 1'b1);
    mv(SBME_MOVE_W, 16'h0000, 0, 1'b0);
    stop_test();
  end
endmodule : sbme_exec_tb_top
`default_nettype wire
